// ### rtl/accl_axis_config.sv
`timescale 1ns/1ps
module accl_axis_config #(
  parameter int IRQ_W = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] rdata_o,
  input wire logic main_status_rd_i,
  input wire logic event_irq_rd_i,
  input wire logic error_irq_rd_i,
  input wire logic [IRQ_W-1:0] event_irq_wclr_i,
  input wire logic [IRQ_W-1:0] error_irq_wclr_i,
  input wire logic [IRQ_W-1:0] event_irq_set_i,
  input wire logic [IRQ_W-1:0] error_irq_set_i,
  input wire logic enable_irq_set_i,
  input wire logic error_irq_set_main_i,
  output logic enable_irq_flag_o,
  output logic error_irq_flag_o,
  output logic [IRQ_W-1:0] event_irq_status_o,
  output logic [IRQ_W-1:0] error_irq_status_o,
  input wire accl_pkg::accl_pulses_t pulses_i,
  input wire logic [1:0] counter2_source_select_i,
  input wire logic [1:0] deviation_pair_select_i,
  input wire logic [1:0] counter4_source_select_i,
  input wire logic [27:0] remaining_pulse_count_i,
  input wire logic [15:0] current_speed_step_i,
  input wire logic [7:0] operation_mode_code_i,
  input wire logic [7:0] run_command_i,
  input wire logic latch_trigger_input_i,
  input wire logic home_sensor_input_i,
  input wire logic end_limit_input_i,
  input wire logic start_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic pulser_ctrl_i,
  input wire logic cmp1_match_i,
  input wire logic cmp2_match_i,
  input wire logic cmp3_match_i,
  input wire logic cmp4_match_i,
  input wire logic accel_start_i,
  input wire logic accel_end_i,
  input wire logic decel_start_i,
  input wire logic decel_end_i,
  input wire logic [3:0] axis_sync_i,
  output logic sync_out_o,
  output logic sync_in_o,
  output logic compare5_output_o,
  output logic stop_now_o,
  output logic decel_stop_o,
  output logic override_o,
  output logic [2:0] idle_pulses_o,
  output logic limit_hold_o,
  output logic limit_error_o,
  output logic pulser_flush_o,
  output logic [1:0] feed_correction_mode_o,
  output logic [11:0] correction_amount_o,
  output logic [10:0] pulser_divider_o,
  output logic [5:0] pulser_gain_o,
  output logic [20:0] reverse_period_cyc_o,
  output logic [20:0] forward_period_cyc_o
);
  accl_pkg::accl_env5_t env5_q;
  accl_pkg::accl_env6_t env6_q;
  accl_pkg::accl_env7_t env7_q;
  logic [27:0] cun1_q, cun2_q, cun4_q, cmp5_q;
  logic [15:0] cun3_q;
  logic [27:0] ltc1_q, ltc2_q, ltc4_q;
  logic [15:0] ltc3_q;
  logic ltc_in_q, org_in_q;
  logic cmp5_q_match, prev_match_q;
  logic [27:0] target;
  logic [1:0] tgt_dir;
  logic hw_latch, capture, limit_err_set;
  logic wr5, wr6, wr7;

  // signed net step from an up/down pair
  function automatic logic [1:0] step_of(input logic up, input logic dn);
    step_of = {dn & ~up, up ^ dn};
  endfunction

  function automatic logic [27:0] add_step(input logic [27:0] v, input logic [1:0] s);
    add_step = s[0] ? (s[1] ? v - 28'h1 : v + 28'h1) : v;
  endfunction

  function automatic logic [31:0] sx28(input logic [27:0] v);
    sx28 = {{4{v[27]}}, v};
  endfunction

  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction

  assign wr5 = cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_ENV5;
  assign wr6 = cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_ENV6;
  assign wr7 = cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_ENV7;

  // reserved bits kept at zero regardless of what is written
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      env5_q <= accl_pkg::ENV5_RST;
      env6_q <= accl_pkg::ENV6_RST;
      env7_q <= accl_pkg::ENV7_RST;
      cmp5_q <= '0;
    end
    else
    begin
      if (wr5)
        env5_q <= cmd_wdata_i & accl_pkg::ENV5_WMASK;
      if (wr6)
        env6_q <= cmd_wdata_i & accl_pkg::ENV6_WMASK;
      if (wr7)
        env7_q <= cmd_wdata_i;
      if (cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_CMP5)
        cmp5_q <= cmd_wdata_i[27:0];
    end
  end

  // counter steps per source
  logic [1:0] s_cmd, s_enc, s_man, s_c2, s_c3, s_c4;
  always_comb
  begin
    s_cmd = step_of(pulses_i.cmd_up, pulses_i.cmd_dn);
    s_enc = step_of(pulses_i.enc_up, pulses_i.enc_dn);
    s_man = step_of(pulses_i.man_up, pulses_i.man_dn);
    case (counter2_source_select_i)
      2'h0: s_c2 = s_enc;
      2'h1: s_c2 = s_cmd;
      2'h2: s_c2 = s_man;
      default: s_c2 = 2'h0;
    endcase
    case (counter4_source_select_i)
      2'h0: s_c4 = s_cmd;
      2'h1: s_c4 = s_enc;
      2'h2: s_c4 = s_man;
      default: s_c4 = 2'h0;
    endcase
    // difference: first of pair counts up, second counts down
    case (deviation_pair_select_i)
      2'h0: s_c3 = (s_cmd == s_enc) ? 2'h0 : (s_cmd[0] ? s_cmd : {~s_enc[1], 1'b1});
      2'h1: s_c3 = (s_cmd == s_man) ? 2'h0 : (s_cmd[0] ? s_cmd : {~s_man[1], 1'b1});
      2'h2: s_c3 = (s_enc == s_man) ? 2'h0 : (s_enc[0] ? s_enc : {~s_man[1], 1'b1});
      default: s_c3 = 2'h0;
    endcase
    // two simultaneous opposite-pair steps of same sign cancel; mixed sign ones rare, counted once
  end

  // comparator 5 target and direction
  always_comb
  begin
    target = '0;
    tgt_dir = 2'h0;
    case (env5_q.cmp5_target_select)
      3'h0: begin target = cun1_q; tgt_dir = s_cmd; end
      3'h1: begin target = cun2_q; tgt_dir = s_c2; end
      3'h2:
      begin
        target = {12'h0, cun3_q[15]
                  ? 16'(-cun3_q) - 16'(cun3_q == ~accl_pkg::DEV_ABS_MAX) : cun3_q};
        tgt_dir = s_c3;
      end
      3'h3: begin target = cun4_q; tgt_dir = s_c4; end
      3'h4: target = remaining_pulse_count_i;
      3'h5: target = {12'h0, current_speed_step_i};
      default: target = '0;
    endcase
  end

  always_comb
  begin
    case (env5_q.cmp5_condition_select)
      3'h1: cmp5_q_match = cmp5_q == target;
      3'h2: cmp5_q_match = (cmp5_q == target) && tgt_dir == 2'h1;
      3'h3: cmp5_q_match = (cmp5_q == target) && tgt_dir == 2'h3;
      3'h4: cmp5_q_match = $signed(cmp5_q) > $signed(target);
      3'h5: cmp5_q_match = $signed(cmp5_q) < $signed(target);
      default: cmp5_q_match = 1'b0;
    endcase
  end

  logic cmp5_rise;
  assign cmp5_rise = cmp5_q_match & ~prev_match_q;

  // match action outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prev_match_q <= 1'b0;
      compare5_output_o <= 1'b0;
      stop_now_o <= 1'b0;
      decel_stop_o <= 1'b0;
      override_o <= 1'b0;
    end
    else
    begin
      prev_match_q <= cmp5_q_match;
      compare5_output_o <= cmp5_q_match;
      stop_now_o <= cmp5_rise && env5_q.cmp5_match_action == accl_pkg::ACCL_ACT_STOP;
      decel_stop_o <= cmp5_rise && env5_q.cmp5_match_action == accl_pkg::ACCL_ACT_DECEL;
      override_o <= cmp5_rise && env5_q.cmp5_match_action == accl_pkg::ACCL_ACT_OVERRIDE;
    end
  end

  // latching
  always_comb
  begin
    case (env5_q.latch_event_select)
      2'h0: hw_latch = latch_trigger_input_i & ~ltc_in_q;
      2'h1: hw_latch = home_sensor_input_i & ~org_in_q;
      2'h2: hw_latch = cmp4_match_i;
      default: hw_latch = cmp5_rise;
    endcase
    capture = (cmd_valid_i && cmd_code_i == accl_pkg::CMD_CAPTURE)
              || (hw_latch && !env5_q.latch_by_command_only);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ltc_in_q <= 1'b0;
      org_in_q <= 1'b0;
      ltc1_q <= '0;
      ltc2_q <= '0;
      ltc3_q <= '0;
      ltc4_q <= '0;
    end
    else
    begin
      ltc_in_q <= latch_trigger_input_i;
      org_in_q <= home_sensor_input_i;
      if (capture)
      begin
        ltc1_q <= cun1_q;
        ltc2_q <= cun2_q;
        ltc4_q <= cun4_q;
        ltc3_q <= env5_q.third_latch_source ? current_speed_step_i : cun3_q;
      end
    end
  end

  // counters; writes drop sign-extension bits
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cun1_q <= '0;
      cun2_q <= '0;
      cun3_q <= '0;
      cun4_q <= '0;
    end
    else
    begin
      if (cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_CUN1)
        cun1_q <= cmd_wdata_i[27:0];
      else if (capture && env5_q.zero_after_capture[0])
        cun1_q <= '0;
      else
        cun1_q <= add_step(cun1_q, s_cmd);
      if (cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_CUN2)
        cun2_q <= cmd_wdata_i[27:0];
      else if (capture && env5_q.zero_after_capture[1])
        cun2_q <= '0;
      else
        cun2_q <= add_step(cun2_q, s_c2);
      if (cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_CUN3)
        cun3_q <= cmd_wdata_i[15:0];
      else if (capture && env5_q.zero_after_capture[2])
        cun3_q <= '0;
      else
        cun3_q <= 16'(add_step({12'h0, cun3_q}, s_c3));
      if (cmd_valid_i && cmd_code_i == accl_pkg::CMD_WR_CUN4)
        cun4_q <= cmd_wdata_i[27:0];
      else if (capture && env5_q.zero_after_capture[3])
        cun4_q <= '0;
      else
        cun4_q <= add_step(cun4_q, s_c4);
    end
  end

  // internal sync
  logic sync_evt;
  always_comb
  begin
    case (env5_q.sync_source_event)
      4'h1: sync_evt = cmp1_match_i;
      4'h2: sync_evt = cmp2_match_i;
      4'h3: sync_evt = cmp3_match_i;
      4'h4: sync_evt = cmp4_match_i;
      4'h5: sync_evt = cmp5_rise;
      4'h8: sync_evt = accel_start_i;
      4'h9: sync_evt = accel_end_i;
      4'ha: sync_evt = decel_start_i;
      4'hb: sync_evt = decel_end_i;
      default: sync_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sync_out_o <= 1'b0;
      sync_in_o <= 1'b0;
    end
    else
    begin
      sync_out_o <= sync_evt;
      sync_in_o <= axis_sync_i[env5_q.sync_input_axis];
    end
  end

  // status flags; set wins over any clear
  logic main_rd_clr, ev_rd_clr, er_rd_clr;
  assign main_rd_clr = main_status_rd_i && !env5_q.main_flag_clear_policy;
  assign ev_rd_clr = event_irq_rd_i && !env5_q.irq_status_clear_policy;
  assign er_rd_clr = error_irq_rd_i && !env5_q.irq_status_clear_policy;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      enable_irq_flag_o <= 1'b0;
      error_irq_flag_o <= 1'b0;
      event_irq_status_o <= '0;
      error_irq_status_o <= '0;
    end
    else
    begin
      if (enable_irq_set_i)
        enable_irq_flag_o <= 1'b1;
      else if (main_rd_clr || (cmd_valid_i && cmd_code_i == accl_pkg::CMD_CLR_ENI))
        enable_irq_flag_o <= 1'b0;
      if (error_irq_set_main_i || limit_err_set)
        error_irq_flag_o <= 1'b1;
      else if (main_rd_clr || (cmd_valid_i && cmd_code_i == accl_pkg::CMD_CLR_ERI))
        error_irq_flag_o <= 1'b0;
      event_irq_status_o <= event_irq_set_i
        | (event_irq_status_o & ~event_irq_wclr_i & {IRQ_W{~ev_rd_clr}});
      error_irq_status_o <= error_irq_set_i
        | (error_irq_status_o & ~error_irq_wclr_i & {IRQ_W{~er_rd_clr}});
    end
  end

  // end limit in continuous modes; hold clears on reverse (behaviour 0) or on start (behaviour 1)
  logic cont_mode;
  assign cont_mode = operation_mode_code_i == 8'h01 || operation_mode_code_i == 8'h02;
  assign limit_err_set = cont_mode && end_limit_input_i && env5_q.limit_stop_behaviour
                         && !limit_hold_o;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      limit_hold_o <= 1'b0;
      limit_error_o <= 1'b0;
    end
    else
    begin
      if (cont_mode && end_limit_input_i && !limit_hold_o)
      begin
        limit_hold_o <= 1'b1;
        limit_error_o <= env5_q.limit_stop_behaviour;
      end
      else if (!end_limit_input_i || (env5_q.limit_stop_behaviour && start_cmd_i))
      begin
        // behaviour 0 leaves the hold once reverse motion takes it off the limit
        limit_hold_o <= limit_hold_o && env5_q.limit_stop_behaviour && !start_cmd_i;
        limit_error_o <= limit_error_o && !start_cmd_i;
      end
    end
  end

  // pulser stop handling
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pulser_flush_o <= 1'b0;
    else
      pulser_flush_o <= stop_cmd_i && pulser_ctrl_i && env6_q.pulser_stop_mode
        && !(run_command_i >= accl_pkg::CMD_INTERP_LO
             && run_command_i <= accl_pkg::CMD_INTERP_HI);
  end

  // configuration fan-out
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      idle_pulses_o <= '0;
      feed_correction_mode_o <= '0;
      correction_amount_o <= '0;
      pulser_divider_o <= '0;
      pulser_gain_o <= '0;
      reverse_period_cyc_o <= '0;
      forward_period_cyc_o <= '0;
    end
    else
    begin
      idle_pulses_o <= (env5_q.pre_run_pulse_count == 3'h0) ? 3'h0
                       : env5_q.pre_run_pulse_count - 3'h1;
      // prohibited code 11 treated as no correction
      feed_correction_mode_o <= (env6_q.feed_correction_mode == 2'h3) ? 2'h0
                                : env6_q.feed_correction_mode;
      correction_amount_o <= env6_q.correction_amount;
      pulser_divider_o <= env6_q.pulser_divider;
      pulser_gain_o <= {1'b0, env6_q.pulser_multiplier} + 6'h1;
      reverse_period_cyc_o <= 21'(env7_q.reverse_pulse_period * accl_pkg::VIB_UNIT_CYC);
      forward_period_cyc_o <= 21'(env7_q.forward_pulse_period * accl_pkg::VIB_UNIT_CYC);
    end
  end

  // read data, registered; sign extension on counters
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (cmd_valid_i)
    begin
      if (cmd_code_i == accl_pkg::CMD_RD_ENV5)
        rdata_o <= env5_q;
      else if (cmd_code_i == accl_pkg::CMD_RD_ENV6)
        rdata_o <= env6_q;
      else if (cmd_code_i == accl_pkg::CMD_RD_ENV7)
        rdata_o <= env7_q;
      else if (cmd_code_i == accl_pkg::CMD_RD_CUN1)
        rdata_o <= sx28(cun1_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_CUN2)
        rdata_o <= sx28(cun2_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_CUN3)
        rdata_o <= sx16(cun3_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_CUN4)
        rdata_o <= sx28(cun4_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_CMP5)
        rdata_o <= sx28(cmp5_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_LTC1)
        rdata_o <= sx28(ltc1_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_LTC2)
        rdata_o <= sx28(ltc2_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_LTC3)
        rdata_o <= env5_q.third_latch_source ? {16'h0, ltc3_q} : sx16(ltc3_q);
      else if (cmd_code_i == accl_pkg::CMD_RD_LTC4)
        rdata_o <= sx28(ltc4_q);
      else
        rdata_o <= '0;
    end
  end
endmodule // accl_axis_config

// ### include/accl_pkg.sv
package accl_pkg;
  // command codes on the command port
  localparam logic [7:0] CMD_RD_ENV5 = 8'he0;
  localparam logic [7:0] CMD_WR_ENV5 = 8'ha0;
  localparam logic [7:0] CMD_RD_ENV6 = 8'he1;
  localparam logic [7:0] CMD_WR_ENV6 = 8'ha1;
  localparam logic [7:0] CMD_RD_ENV7 = 8'he2;
  localparam logic [7:0] CMD_WR_ENV7 = 8'ha2;
  localparam logic [7:0] CMD_RD_CUN1 = 8'he3;
  localparam logic [7:0] CMD_WR_CUN1 = 8'ha3;
  localparam logic [7:0] CMD_RD_CUN2 = 8'he4;
  localparam logic [7:0] CMD_WR_CUN2 = 8'ha4;
  localparam logic [7:0] CMD_RD_CUN3 = 8'he5;
  localparam logic [7:0] CMD_WR_CUN3 = 8'ha5;
  localparam logic [7:0] CMD_RD_CUN4 = 8'he6;
  localparam logic [7:0] CMD_WR_CUN4 = 8'ha6;
  localparam logic [7:0] CMD_RD_CMP5 = 8'heb;
  localparam logic [7:0] CMD_WR_CMP5 = 8'hab;
  localparam logic [7:0] CMD_RD_LTC1 = 8'hed;
  localparam logic [7:0] CMD_RD_LTC2 = 8'hee;
  localparam logic [7:0] CMD_RD_LTC3 = 8'hef;
  localparam logic [7:0] CMD_RD_LTC4 = 8'hf0;
  localparam logic [7:0] CMD_CAPTURE = 8'h29;
  localparam logic [7:0] CMD_CLR_ENI = 8'h2d;
  localparam logic [7:0] CMD_CLR_ERI = 8'h2e;
  localparam logic [7:0] CMD_INTERP_LO = 8'h68;
  localparam logic [7:0] CMD_INTERP_HI = 8'h6d;
  localparam logic [31:0] ENV5_WMASK = 32'h0fff_ffff;
  localparam logic [31:0] ENV6_WMASK = 32'hffff_bfff;
  localparam logic [31:0] ENV5_RST = 32'h0000_0000;
  localparam logic [31:0] ENV6_RST = 32'h0000_0000;
  localparam logic [31:0] ENV7_RST = 32'h0000_0000;
  localparam int VIB_UNIT_CYC = 32;
  localparam int CNT_W = 28;
  localparam int DEV_W = 16;
  localparam logic [15:0] DEV_ABS_MAX = 16'h7fff;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [3:0] zero_after_capture;
    logic irq_status_clear_policy;
    logic main_flag_clear_policy;
    logic [1:0] sync_input_axis;
    logic [3:0] sync_source_event;
    logic latch_by_command_only;
    logic third_latch_source;
    logic [1:0] latch_event_select;
    logic limit_stop_behaviour;
    logic [2:0] pre_run_pulse_count;
    logic [1:0] cmp5_match_action;
    logic [2:0] cmp5_condition_select;
    logic [2:0] cmp5_target_select;
  } accl_env5_t;

  typedef struct packed {
    logic [4:0] pulser_multiplier;
    logic [10:0] pulser_divider;
    logic pulser_stop_mode;
    logic rsvd;
    logic [1:0] feed_correction_mode;
    logic [11:0] correction_amount;
  } accl_env6_t;

  typedef struct packed {
    logic [15:0] forward_pulse_period;
    logic [15:0] reverse_pulse_period;
  } accl_env7_t;

  // count pulses on each source, one cycle each
  typedef struct packed {
    logic cmd_up;
    logic cmd_dn;
    logic enc_up;
    logic enc_dn;
    logic man_up;
    logic man_dn;
  } accl_pulses_t;

  typedef enum logic [1:0] {
    ACCL_ACT_NONE = 2'b00,
    ACCL_ACT_STOP = 2'b01,
    ACCL_ACT_DECEL = 2'b10,
    ACCL_ACT_OVERRIDE = 2'b11
  } accl_action_t;
endpackage

// ### tb/accl_axis_monitor.sv
`timescale 1ns/1ps
module accl_axis_monitor #(
  parameter int IRQ_W = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic enable_irq_set_i,
  input wire logic enable_irq_flag_o,
  input wire logic [3:0] axis_sync_i,
  input wire logic sync_in_o,
  input wire logic sync_out_o,
  input wire logic stop_now_o,
  input wire logic decel_stop_o,
  input wire logic override_o,
  input wire logic [2:0] idle_pulses_o,
  input wire logic [1:0] feed_correction_mode_o,
  input wire logic [5:0] pulser_gain_o,
  input wire logic [20:0] reverse_period_cyc_o
);
  accl_pkg::accl_env5_t s5_q;
  accl_pkg::accl_env6_t s6_q;
  accl_pkg::accl_env7_t s7_q;
  logic [1:0] age_q;
  logic [2:0] act;
  logic any;
  assign act = 3'((4'h1 << s5_q.cmp5_match_action) >> 1);
  assign any = cmd_valid_i && cmd_code_i[7:2] == 6'h28;
  // shadow copy; outputs judged after two quiet edges
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s5_q <= accl_pkg::ENV5_RST;
      s6_q <= accl_pkg::ENV6_RST;
      s7_q <= accl_pkg::ENV7_RST;
    end
    else if (cmd_valid_i)
    begin
      if (cmd_code_i == accl_pkg::CMD_WR_ENV5)
        s5_q <= cmd_wdata_i & accl_pkg::ENV5_WMASK;
      if (cmd_code_i == accl_pkg::CMD_WR_ENV6)
        s6_q <= cmd_wdata_i & accl_pkg::ENV6_WMASK;
      if (cmd_code_i == accl_pkg::CMD_WR_ENV7)
        s7_q <= cmd_wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || any)
      age_q <= 2'h0;
    else if (age_q != 2'h2)
      age_q <= age_q + 2'h1;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_idle_count_map: assert property (age_q == 2'h2 |-> idle_pulses_o ==
    ((s5_q.pre_run_pulse_count == 3'h0) ? 3'h0 : s5_q.pre_run_pulse_count - 3'h1))
    else $error("idle pulse count off");
  a_vib_reverse_scale: assert property (age_q == 2'h2 |->
    reverse_period_cyc_o == {s7_q.reverse_pulse_period, 5'h00}) else $error("period off");
  a_pulser_gain_map: assert property (age_q == 2'h2 |->
    pulser_gain_o == {1'b0, s6_q.pulser_multiplier} + 6'h01) else $error("gain off");
  a_corr_mode_legal: assert property (age_q == 2'h2 |-> feed_correction_mode_o ==
    ((s6_q.feed_correction_mode == 2'h3) ? 2'h0 : s6_q.feed_correction_mode))
    else $error("correction mode off");
  a_sync_in_axis: assert property (age_q == 2'h2 && $past(age_q) == 2'h2 |->
    sync_in_o == $past(axis_sync_i[s5_q.sync_input_axis])) else $error("sync in off");
  a_action_one_pulse: assert property (stop_now_o || decel_stop_o || override_o |=>
    !(stop_now_o || decel_stop_o || override_o)) else $error("action not a pulse");
  a_action_by_field: assert property (age_q == 2'h2 |->
    ({override_o, decel_stop_o, stop_now_o} & ~act) == 3'h0) else $error("wrong action");
  a_main_flag_clear: assert property (cmd_valid_i && !enable_irq_set_i &&
    cmd_code_i == accl_pkg::CMD_CLR_ENI |=> !enable_irq_flag_o) else $error("flag kept");
  c_stop: cover property (stop_now_o);
  c_sync: cover property (sync_out_o);
  c_flag: cover property ($fell(enable_irq_flag_o));
endmodule // accl_axis_monitor
bind accl_axis_config accl_axis_monitor #(.IRQ_W(IRQ_W)) accl_axis_monitor_inst (.*);

// ### tb/accl_motor_model.sv
`timescale 1ns/1ps
module accl_motor_model (
  input wire logic clk_sys_i,
  input wire logic en_i,
  output accl_pkg::accl_pulses_t pulses_o
);
  // one count edge a cycle at most, like a decoder
  always @(posedge clk_sys_i)
    pulses_o <= en_i ? 6'(6'h01 << $urandom_range(0, 7)) : 6'h00;
endmodule // accl_motor_model

// ### tb/accl_axis_config_test.sv
`timescale 1ns/1ps
module accl_axis_config_test;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, cv = 1'b0, latch_trigger_input = 1'b0, home = 1'b0, elim = 1'b0, nz = 1'b0;
  logic [7:0] cc = 8'h00, ev = 8'h00;
  logic [31:0] cw = 32'h0, iset = 32'h0, iclr = 32'h0;
  logic [4:0] st = 5'h00, seen;
  logic [3:0] axs = 4'h0, m;
  logic [5:0] sel = 6'h00;
  logic [27:0] remain = 28'h0;
  logic [15:0] speed = 16'h0;
  accl_pkg::accl_pulses_t pulses;
  accl_pkg::accl_env5_t e;
  logic [31:0] rdata, ev_st, er_st, v, w, got;
  logic en_f, er_f, c5, stp, dec, ovr, sy;
  logic [7:0] wcd [4] = '{8'ha3, 8'ha4, 8'ha6, 8'ha5};
  logic [31:0] tv [3] = '{32'h07ff_ffff, 32'h0800_0000, 32'h0000_8000};
  logic [3:0] sc [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'h0, 4'h6};
  int error_cnt = 0, compares = 0;
  accl_axis_config accl_axis_config_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_wdata_i(cw),
    .rdata_o(rdata), .main_status_rd_i(st[2]), .event_irq_rd_i(st[3]), .error_irq_rd_i(st[4]),
    .event_irq_wclr_i(iclr), .error_irq_wclr_i(iclr), .event_irq_set_i(iset),
    .error_irq_set_i(iset), .enable_irq_set_i(st[0]), .error_irq_set_main_i(st[1]),
    .enable_irq_flag_o(en_f), .error_irq_flag_o(er_f), .event_irq_status_o(ev_st),
    .error_irq_status_o(er_st), .pulses_i(pulses), .counter2_source_select_i(sel[1:0]),
    .deviation_pair_select_i(sel[3:2]), .counter4_source_select_i(sel[5:4]),
    .remaining_pulse_count_i(remain), .current_speed_step_i(speed),
    .operation_mode_code_i(8'h00), .run_command_i(8'h00), .latch_trigger_input_i(latch_trigger_input),
    .home_sensor_input_i(home), .end_limit_input_i(elim), .start_cmd_i(1'b0), .stop_cmd_i(1'b0),
    .pulser_ctrl_i(1'b0), .cmp1_match_i(ev[0]), .cmp2_match_i(ev[1]), .cmp3_match_i(ev[2]),
    .cmp4_match_i(ev[3]), .accel_start_i(ev[4]), .accel_end_i(ev[5]), .decel_start_i(ev[6]),
    .decel_end_i(ev[7]), .axis_sync_i(axs), .sync_out_o(sy), .sync_in_o(),
    .compare5_output_o(c5), .stop_now_o(stp), .decel_stop_o(dec), .override_o(ovr),
    .idle_pulses_o(), .limit_hold_o(), .limit_error_o(), .pulser_flush_o(),
    .feed_correction_mode_o(), .correction_amount_o(), .pulser_divider_o(),
    .pulser_gain_o(), .reverse_period_cyc_o(), .forward_period_cyc_o());
  accl_motor_model accl_motor_model_inst (.clk_sys_i(clk_sys_i), .en_i(nz), .pulses_o(pulses));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] sx28(input logic [31:0] x);
    return {{4{x[27]}}, x[27:0]};
  endfunction
  function automatic logic [31:0] sx16(input logic [31:0] x);
    return {{16{x[15]}}, x[15:0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    @(posedge clk_sys_i);
    cv <= 1'b1;
    cc <= c;
    cw <= d;
    @(posedge clk_sys_i);
    cv <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic strb(input logic [4:0] s, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk_sys_i);
    st <= s;
    iset <= a;
    iclr <= b;
    @(posedge clk_sys_i);
    st <= 5'h00;
    iset <= 32'h0;
    iclr <= 32'h0;
    #1;
  endtask
  task automatic setrs(input logic [27:0] r, input logic [15:0] s);
    @(posedge clk_sys_i);
    remain <= r;
    speed <= s;
  endtask
  task automatic trig();
    @(posedge clk_sys_i);
    latch_trigger_input <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    latch_trigger_input <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic watch();
    seen = 5'h00;
    repeat (8)
    begin
      #1;
      seen = seen | {sy, c5, ovr, dec, stp};
      @(posedge clk_sys_i);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    if (nz)
    begin
      axs <= 4'($urandom);
      sel <= 6'($urandom);
      home <= 1'($urandom);
      elim <= 1'($urandom);
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(92993));
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    nz <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom & accl_pkg::ENV5_WMASK;
      w = $urandom & accl_pkg::ENV6_WMASK & 32'hffff_dfff;
      cmd(accl_pkg::CMD_WR_ENV5, v);
      cmd(accl_pkg::CMD_WR_ENV6, w);
      cmd(accl_pkg::CMD_WR_ENV7, v ^ w);
      cmd(accl_pkg::CMD_RD_ENV5, 32'h0);
      chk(got, v);
      cmd(accl_pkg::CMD_RD_ENV6, 32'h0);
      chk(got, w);
      cmd(accl_pkg::CMD_RD_ENV7, 32'h0);
      chk(got, v ^ w);
    end
    cmd(8'hff, 32'h0);
    chk(got, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      cmd(accl_pkg::CMD_WR_ENV5, 32'(p) * 32'h00c0_0000);
      v = $urandom;
      strb(5'h03, v, 32'h0);
      chk(ev_st, v);
      strb(5'h1c, 32'h0, 32'h0);
      chk(er_st, p ? v : 32'h0);
      chk({30'h0, en_f, er_f}, p ? 32'h3 : 32'h0);
      w = $urandom;
      strb(5'h00, 32'h0, w);
      chk(ev_st, (p ? v : 32'h0) & ~w);
      cmd(accl_pkg::CMD_CLR_ENI, 32'h0);
      cmd(accl_pkg::CMD_CLR_ERI, 32'h0);
      chk({30'h0, en_f, er_f}, 32'h0);
    end
    nz <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 3) ? tv[i] : $urandom;
      for (int j = 0; j < 4; j++)
      begin
        cmd(wcd[j], v);
        cmd(wcd[j] | 8'h40, 32'h0);
        chk(got, (j == 3) ? sx16(v) : sx28(v));
      end
    end
    e = '0;
    e.latch_by_command_only = 1'b1;
    e.zero_after_capture = 4'h1;
    cmd(accl_pkg::CMD_WR_ENV5, e);
    v = $urandom;
    w = $urandom;
    cmd(accl_pkg::CMD_WR_CUN1, v);
    cmd(accl_pkg::CMD_WR_CUN2, v);
    cmd(accl_pkg::CMD_WR_CUN3, v);
    cmd(accl_pkg::CMD_CAPTURE, 32'h0);
    cmd(accl_pkg::CMD_RD_LTC1, 32'h0);
    chk(got, sx28(v));
    cmd(accl_pkg::CMD_RD_CUN1, 32'h0);
    chk(got, 32'h0);
    cmd(accl_pkg::CMD_RD_CUN2, 32'h0);
    chk(got, sx28(v));
    cmd(accl_pkg::CMD_RD_LTC3, 32'h0);
    chk(got, sx16(v));
    cmd(accl_pkg::CMD_WR_CUN1, w);
    trig();
    cmd(accl_pkg::CMD_RD_LTC1, 32'h0);
    chk(got, sx28(v));
    e.latch_by_command_only = 1'b0;
    e.third_latch_source = 1'b1;
    cmd(accl_pkg::CMD_WR_ENV5, e);
    setrs(remain, 16'($urandom));
    trig();
    cmd(accl_pkg::CMD_RD_LTC1, 32'h0);
    chk(got, sx28(w));
    cmd(accl_pkg::CMD_RD_LTC3, 32'h0);
    chk(got, {16'h0, speed});
    cmd(accl_pkg::CMD_RD_CUN1, 32'h0);
    chk(got, 32'h0);
    setrs(28'd2000, 16'd500);
    cmd(accl_pkg::CMD_WR_CMP5, 32'd1000);
    for (int i = 0; i < 6; i++)
    begin
      e = '0;
      e.cmp5_target_select = (i == 5) ? 3'h5 : 3'h4;
      e.cmp5_condition_select = (i == 5) ? 3'h5 : ((i == 4) ? 3'h0 : 3'h4);
      e.cmp5_match_action = 2'(i);
      e.sync_source_event = 4'h5;
      cmd(accl_pkg::CMD_WR_ENV5, e);
      setrs(28'd500, 16'd2000);
      watch();
      m = (4'h1 << 2'(i)) >> 1;
      chk({27'h0, seen}, (i == 4) ? 32'h0 : {27'h0, 2'h3, m[2:0]});
      setrs(28'd2000, 16'd500);
      watch();
    end
    for (int i = 0; i < 10; i++)
    begin
      e = '0;
      e.sync_source_event = sc[i];
      cmd(accl_pkg::CMD_WR_ENV5, e);
      @(posedge clk_sys_i);
      ev <= (i < 8) ? 8'(8'h01 << i) : 8'hff;
      @(posedge clk_sys_i);
      ev <= 8'h00;
      watch();
      chk({31'h0, seen[4]}, (i < 8) ? 32'h1 : 32'h0);
    end
    end_of_test();
  end
endmodule // accl_axis_config_test
